// [logic/usb_pipe_status_and_frame_number.sv]
// Purpose: per-pipe not-ready / buffer-empty status, interrupt summaries, frame number
// Assumes: all event inputs are one-cycle pulses synchronous to sys_clk
// Notes: wishbone answers one cycle after the request; ack drops the cycle after
`timescale 1ns/10ps
module usb_pipe_status_and_frame_number (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pipe_not_ready_event,
  input wire logic [7:0] pipe_buffer_empty_event,
  input wire logic buffer_ready_event,
  input wire logic sof_received,
  input wire logic [10:0] sof_frame_number,
  input wire logic sof_interp_tick,
  input wire logic sof_missing,
  input wire logic iso_rx_packet,
  input wire logic [2:0] iso_rx_pipe,
  input wire logic iso_rx_buffer_busy,
  input wire logic iso_rx_packet_error,
  input wire logic iso_in_token,
  input wire logic [2:0] iso_tx_pipe,
  input wire logic iso_tx_buffer_unwritten,
  output logic iso_rx_discard,
  output logic iso_tx_zero_length,
  output logic [3:0] summary_flags
);

  // ****************************************
  // bus slave
  // ****************************************
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic req;
  logic wr_fire;
  logic [7:0] idx;
  logic lo_en;
  logic hi_en;

  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[9:2];
  // writes take effect at the edge where ack is seen high
  assign wr_fire = req & wb_we_i & ack_reg;
  assign lo_en = wb_sel_i[0];
  assign hi_en = wb_sel_i[1];
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // ****************************************
  // register selects
  // ****************************************
  logic hit_first_status;
  logic hit_second_status;
  logic hit_not_ready;
  logic hit_buffer_empty;
  logic hit_frame;

  // only the word index takes part; other address bits are don't-care
  assign hit_first_status = (idx == pipe_status_pkg::first_interrupt_status_idx);
  assign hit_second_status = (idx == pipe_status_pkg::second_interrupt_status_idx);
  assign hit_not_ready = (idx == pipe_status_pkg::pipe_not_ready_status_idx);
  assign hit_buffer_empty = (idx == pipe_status_pkg::pipe_buffer_empty_status_idx);
  assign hit_frame = (idx == pipe_status_pkg::frame_number_and_iso_errors_idx);

  // ****************************************
  // decode of write-zero clears
  // ****************************************
  logic [7:0] not_ready_summary_flags;
  logic [7:0] buffer_empty_summary_flags;
  logic [7:0] not_ready_summary_clr;
  logic [7:0] buffer_empty_summary_clr;
  logic [7:0] not_ready_summary_set;
  logic [1:0] err_flags;
  logic [1:0] err_clr;
  logic [1:0] err_set;
  logic [1:0] irq_flags;
  logic [1:0] irq_clr;
  logic [1:0] irq_set;
  logic wr_not_ready_summary;
  logic wr_buffer_empty_summary;
  logic wr_frame;
  logic wr_summary;

  assign wr_not_ready_summary = wr_fire & hit_not_ready;
  assign wr_buffer_empty_summary = wr_fire & hit_buffer_empty;
  assign wr_frame = wr_fire & hit_frame;
  // either status register clears the shared frame-refresh and buffer-ready summary bits
  assign wr_summary = wr_fire & hi_en & (hit_first_status | hit_second_status);

  // the pipe registers back only the low byte; their upper byte writes go nowhere
  assign not_ready_summary_clr = {8{wr_not_ready_summary & lo_en}} & ~wb_dat_i[7:0];
  assign buffer_empty_summary_clr = {8{wr_buffer_empty_summary & lo_en}} & ~wb_dat_i[7:0];
  assign err_clr = {2{wr_frame & hi_en}} &
    ~{wb_dat_i[pipe_status_pkg::overrun_flag_bit],
      wb_dat_i[pipe_status_pkg::receive_error_flag_bit]};
  assign irq_clr = {2{wr_summary}} &
    ~{wb_dat_i[pipe_status_pkg::frame_refresh_summary_bit],
      wb_dat_i[pipe_status_pkg::buffer_ready_summary_bit]};

  // ****************************************
  // isochronous error handling
  // ****************************************
  logic rx_overrun;
  logic rx_error;
  logic tx_underrun;
  logic [7:0] iso_not_ready_summary;

  assign rx_overrun = iso_rx_packet & iso_rx_buffer_busy;
  assign rx_error = iso_rx_packet & iso_rx_packet_error & ~iso_rx_buffer_busy;
  assign tx_underrun = iso_in_token & iso_tx_buffer_unwritten;

  always_comb begin
    iso_not_ready_summary = 8'h00;
    if (rx_overrun | rx_error) begin
      iso_not_ready_summary[iso_rx_pipe] = 1'b1;
    end
    if (tx_underrun) begin
      iso_not_ready_summary[iso_tx_pipe] = 1'b1;
    end
  end

  assign not_ready_summary_set = pipe_not_ready_event | iso_not_ready_summary;
  assign err_set = {rx_overrun | tx_underrun, rx_error};

  // one-cycle strobes; the serial engine acts on each high cycle, so no stretching
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      iso_rx_discard <= 1'b0;
    end else begin
      iso_rx_discard <= rx_overrun | rx_error;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      iso_tx_zero_length <= 1'b0;
    end else begin
      iso_tx_zero_length <= tx_underrun;
    end
  end

  // ****************************************
  // flag banks
  // ****************************************
  sticky_flags #(.width(8)) u_not_ready_summary (
    .sys_clk(sys_clk),
    .rst(rst),
    .set(not_ready_summary_set),
    .clr(not_ready_summary_clr),
    .flags(not_ready_summary_flags)
  );

  sticky_flags #(.width(8)) u_buffer_empty_summary (
    .sys_clk(sys_clk),
    .rst(rst),
    .set(pipe_buffer_empty_event),
    .clr(buffer_empty_summary_clr),
    .flags(buffer_empty_summary_flags)
  );

  sticky_flags #(.width(2)) u_err (
    .sys_clk(sys_clk),
    .rst(rst),
    .set(err_set),
    .clr(err_clr),
    .flags(err_flags)
  );

  sticky_flags #(.width(2)) u_irq (
    .sys_clk(sys_clk),
    .rst(rst),
    .set(irq_set),
    .clr(irq_clr),
    .flags(irq_flags)
  );

  // ****************************************
  // frame number and refresh interrupt
  // ****************************************
  logic mode_reg;
  logic [10:0] frame_reg;
  logic frame_refresh;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= pipe_status_pkg::frame_interrupt_mode_reset;
    end else if (wr_frame & hi_en) begin
      mode_reg <= wb_dat_i[pipe_status_pkg::frame_interrupt_mode_bit];
    end
  end

  // software has no path into the frame number; a missed frame keeps the old one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_reg <= pipe_status_pkg::frame_number_reset;
    end else if (sof_received) begin
      frame_reg <= sof_frame_number;
    end
  end

  always_comb begin
    if (mode_reg) begin
      frame_refresh = sof_missing;
    end else begin
      frame_refresh = sof_received | sof_interp_tick;
    end
  end

  assign irq_set = {frame_refresh, buffer_ready_event};

  // ****************************************
  // read side
  // ****************************************
  logic [15:0] summary_word;
  logic [15:0] frame_word;
  logic [15:0] read_word;

  always_comb begin
    summary_word = pipe_status_pkg::reg_zero;
    summary_word[pipe_status_pkg::frame_refresh_summary_bit] = irq_flags[1];
    summary_word[pipe_status_pkg::buffer_empty_summary_bit] = |buffer_empty_summary_flags;
    summary_word[pipe_status_pkg::not_ready_summary_bit] = |not_ready_summary_flags;
    summary_word[pipe_status_pkg::buffer_ready_summary_bit] = irq_flags[0];
  end

  always_comb begin
    frame_word = pipe_status_pkg::reg_zero;
    frame_word[pipe_status_pkg::overrun_flag_bit] = err_flags[1];
    frame_word[pipe_status_pkg::receive_error_flag_bit] = err_flags[0];
    frame_word[pipe_status_pkg::frame_interrupt_mode_bit] = mode_reg;
    frame_word[pipe_status_pkg::frame_number_msb:0] = frame_reg;
  end

  always_comb begin
    read_word = pipe_status_pkg::reg_zero;
    if (hit_first_status) begin
      read_word = summary_word;
    end else if (hit_second_status) begin
      read_word = summary_word;
    end else if (hit_not_ready) begin
      read_word = {8'h00, not_ready_summary_flags};
    end else if (hit_buffer_empty) begin
      read_word = {8'h00, buffer_empty_summary_flags};
    end else if (hit_frame) begin
      read_word = frame_word;
    end
  end

  // data is captured as ack rises, so it shows state one cycle before the ack edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else if (req & ~ack_reg) begin
      rdata_reg <= {16'h0000, read_word};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      summary_flags <= 4'h0;
    end else begin
      summary_flags <= {irq_flags[1], |buffer_empty_summary_flags, |not_ready_summary_flags, irq_flags[0]};
    end
  end

endmodule

// [logic/pipe_status_pkg.sv]
// Purpose: shared constants of the pipe status and frame number bank
// Assumes: 32-bit classic wishbone, word index = printed offset, byte address = 4 x index
// Notes: registers are 16 bits wide in the low half of the data word
package pipe_status_pkg;

  // ****************************************
  // register indexes (byte address is index times four)
  // ****************************************
  localparam logic [7:0] first_interrupt_status_idx = 8'h40;
  localparam logic [7:0] second_interrupt_status_idx = 8'h42;
  localparam logic [7:0] pipe_not_ready_status_idx = 8'h48;
  localparam logic [7:0] pipe_buffer_empty_status_idx = 8'h4a;
  localparam logic [7:0] frame_number_and_iso_errors_idx = 8'h4c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int pipe_count = 8;
  localparam int pipe_flags_msb = 7;
  localparam int frame_refresh_summary_bit = 13;
  localparam int buffer_empty_summary_bit = 10;
  localparam int not_ready_summary_bit = 9;
  localparam int buffer_ready_summary_bit = 8;
  localparam int overrun_flag_bit = 15;
  localparam int receive_error_flag_bit = 14;
  localparam int frame_interrupt_mode_bit = 11;
  localparam int frame_number_msb = 10;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] pipe_flags_reset = 8'h00;
  localparam logic [10:0] frame_number_reset = 11'h000;
  localparam logic frame_interrupt_mode_reset = 1'b0;
  localparam logic [15:0] reg_zero = 16'h0000;

  // ****************************************
  // timing
  // ****************************************
  localparam int clk_period_ps = 8000;
  localparam int clear_spacing_ns = 100;
  localparam int clear_spacing_cycles =
    (clear_spacing_ns * 1000 + clk_period_ps - 1) / clk_period_ps;

endpackage

// [logic/sticky_flags.sv]
// Purpose: bank of sticky flags, hardware sets, software clears
// Assumes: set and clear are one-cycle strobes
// Notes: set wins over clear in the same cycle
`timescale 1ns/10ps
module sticky_flags #(
  parameter int width = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [width-1:0] set,
  input wire logic [width-1:0] clr,
  output logic [width-1:0] flags
);

  // a clear in the same cycle as an event must not lose the event
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags <= set | (flags & ~clr);
    end
  end

endmodule

// [dv/usb_pipe_status_props.sv]
// Purpose: port assertions for the pipe status and frame number bank
// Assumes: one clock domain, asynchronous active-high reset
// Notes: bound to every instance of the bank
`timescale 1ns/10ps
module usb_pipe_status_props (
  input wire logic sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [31:0] wb_adr_i, wb_dat_o,
  input wire logic [7:0] pipe_not_ready_event, pipe_buffer_empty_event,
  input wire logic iso_rx_packet, iso_rx_buffer_busy, iso_rx_packet_error, iso_in_token,
  input wire logic iso_tx_buffer_unwritten, iso_rx_discard, iso_tx_zero_length,
  input wire logic [3:0] summary_flags
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_answer; s_req |=> s_ack_pulse; endproperty
  property p_hi_zero;
    wb_ack_o && !wb_we_i && (wb_adr_i[9:2] == 8'h48 || wb_adr_i[9:2] == 8'h4a)
      |-> wb_dat_o[15:8] == 8'h00;
  endproperty
  property p_nr_sum; |pipe_not_ready_event |=> ##1 summary_flags[1]; endproperty
  property p_be_sum; |pipe_buffer_empty_event |=> ##1 summary_flags[2]; endproperty
  property p_rx_drop;
    iso_rx_discard == $past(iso_rx_packet && (iso_rx_buffer_busy || iso_rx_packet_error));
  endproperty
  property p_rx_nr; iso_rx_packet && iso_rx_buffer_busy |=> ##1 summary_flags[1]; endproperty
  property p_zlp; iso_tx_zero_length == $past(iso_in_token && iso_tx_buffer_unwritten); endproperty
  property p_tx_nr; iso_in_token && iso_tx_buffer_unwritten |=> ##1 summary_flags[1]; endproperty
  a_answer: assert property (p_answer) else $error("ack not a single pulse after request");
  a_hi_zero: assert property (p_hi_zero) else $error("upper status bits not zero");
  a_nr_sum: assert property (p_nr_sum) else $error("not-ready summary missing");
  a_be_sum: assert property (p_be_sum) else $error("buffer-empty summary missing");
  a_rx_drop: assert property (p_rx_drop) else $error("rx discard wrong");
  a_rx_nr: assert property (p_rx_nr) else $error("rx overrun gave no not-ready");
  a_zlp: assert property (p_zlp) else $error("zero-length reply wrong");
  a_tx_nr: assert property (p_tx_nr) else $error("tx underrun gave no not-ready");
endmodule
bind usb_pipe_status_and_frame_number usb_pipe_status_props i_props (.sys_clk, .rst,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_dat_o, .pipe_not_ready_event,
  .pipe_buffer_empty_event, .iso_rx_packet, .iso_rx_buffer_busy, .iso_rx_packet_error,
  .iso_in_token, .iso_tx_buffer_unwritten, .iso_rx_discard, .iso_tx_zero_length, .summary_flags);

// [dv/usb_host_model.sv]
// Purpose: serial-engine side events as a host exchange would cause them
// Assumes: events are one-cycle pulses, qualifiers valid with the pulse
// Notes: once released, the frame number bus shows garbage, not the last value
`timescale 1ns/10ps
module usb_host_model (
  input wire logic sys_clk,
  output logic [7:0] pipe_not_ready_event, pipe_buffer_empty_event,
  output logic buffer_ready_event, sof_received, sof_interp_tick, sof_missing,
  output logic [10:0] sof_frame_number,
  output logic iso_rx_packet, iso_rx_buffer_busy, iso_rx_packet_error, iso_in_token,
  output logic [2:0] iso_rx_pipe, iso_tx_pipe,
  output logic iso_tx_buffer_unwritten
);
  // ****************************************
  // event driver
  // ****************************************
  initial begin
    {pipe_not_ready_event, pipe_buffer_empty_event, buffer_ready_event, sof_received} = '0;
    {sof_interp_tick, sof_missing, sof_frame_number, iso_rx_packet, iso_in_token} = '0;
    {iso_rx_buffer_busy, iso_rx_packet_error, iso_tx_buffer_unwritten} = '0;
    {iso_rx_pipe, iso_tx_pipe} = '0;
  end
  // k = {buffer ready, sof, interp, missing, rx packet, in token}; lv = {busy, crc, unwritten}
  task automatic fire(input logic [7:0] nr, be, input logic [5:0] k,
                      input logic [2:0] lv, p, input logic [10:0] fn);
    @(posedge sys_clk);
    {pipe_not_ready_event, pipe_buffer_empty_event} <= {nr, be};
    {buffer_ready_event, sof_received, sof_interp_tick, sof_missing} <= k[5:2];
    {iso_rx_packet, iso_in_token} <= k[1:0];
    {iso_rx_buffer_busy, iso_rx_packet_error, iso_tx_buffer_unwritten} <= lv;
    {iso_rx_pipe, iso_tx_pipe, sof_frame_number} <= {p, p, fn};
    @(posedge sys_clk);
    {pipe_not_ready_event, pipe_buffer_empty_event, buffer_ready_event, sof_received} <= '0;
    {sof_interp_tick, sof_missing, iso_rx_packet, iso_in_token} <= '0;
    {iso_rx_buffer_busy, iso_rx_packet_error, iso_tx_buffer_unwritten} <= '0;
    sof_frame_number <= ~fn;
  endtask
endmodule

// [dv/test_usb_pipe_status_and_frame_number.sv]
// Purpose: self-checking bench for the pipe status and frame number bank
// Assumes: classic wishbone master, one idle cycle between requests
// Notes: register index times four is the byte address
`timescale 1ns/10ps
module test_usb_pipe_status_and_frame_number;
  // ****************************************
  // harness
  // ****************************************
  logic sys_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0] wb_sel_i = 4'h0, summary_flags;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
  logic [7:0] nr, be;
  logic [10:0] fn;
  logic [2:0] rp, tp;
  logic br, sr, st, sm, rx, rb, re, it, tu, rd, zl;
  logic [15:0] q;
  int mismatches = 0, n_tests = 0;
  int n_drop = 0, n_zlp = 0;
  always #4 sys_clk = ~sys_clk;
  // strobes are counted mid-cycle, where they have settled
  always @(negedge sys_clk) begin
    n_drop <= n_drop + int'(rd);
    n_zlp <= n_zlp + int'(zl);
  end
  usb_host_model i_host (.sys_clk, .pipe_not_ready_event(nr), .pipe_buffer_empty_event(be),
    .buffer_ready_event(br), .sof_received(sr), .sof_interp_tick(st), .sof_missing(sm),
    .sof_frame_number(fn), .iso_rx_packet(rx), .iso_rx_buffer_busy(rb),
    .iso_rx_packet_error(re), .iso_in_token(it), .iso_rx_pipe(rp), .iso_tx_pipe(tp),
    .iso_tx_buffer_unwritten(tu));
  usb_pipe_status_and_frame_number i_dut (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pipe_not_ready_event(nr),
    .pipe_buffer_empty_event(be), .buffer_ready_event(br), .sof_received(sr),
    .sof_frame_number(fn), .sof_interp_tick(st), .sof_missing(sm), .iso_rx_packet(rx),
    .iso_rx_pipe(rp), .iso_rx_buffer_busy(rb), .iso_rx_packet_error(re), .iso_in_token(it),
    .iso_tx_pipe(tp), .iso_tx_buffer_unwritten(tu), .iso_rx_discard(rd),
    .iso_tx_zero_length(zl), .summary_flags);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // no fixed latency is assumed; a wait ends on ack, or after 20 cycles if no ack comes
  task automatic wb(input logic we, input logic [7:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hf};
    {wb_adr_i, wb_dat_i} <= {22'h0, idx, 2'h0, 16'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[15:0];
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (n >= 20) chk("ack", 16'h0, 16'h1);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0);
    chk($sformatf("reg %h", idx), q, exp);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rc(8'h48, 16'h0000);
    rc(8'h4a, 16'h0000);
    rc(8'h4c, 16'h0000);
    wb(1'b1, 8'h7e, 16'hffff);
    rc(8'h7e, 16'h0000);
  endtask
  task automatic t_pipes();
    i_host.fire(8'h81, 8'h24, 6'h0, 3'h0, 3'h0, 11'h0);
    rc(8'h48, 16'h0081);
    rc(8'h4a, 16'h0024);
    rc(8'h42, 16'h0600);
    wb(1'b1, 8'h48, 16'hff7f);
    rc(8'h48, 16'h0001);
    repeat (13) @(posedge sys_clk);
    wb(1'b1, 8'h48, 16'hfffe);
    wb(1'b1, 8'h4a, 16'h0000);
    rc(8'h40, 16'h0000);
    fork
      begin
        @(posedge sys_clk);
        i_host.fire(8'h10, 8'h0, 6'h0, 3'h0, 3'h0, 11'h0);
      end
      wb(1'b1, 8'h48, 16'h0000);
    join
    rc(8'h48, 16'h0010);
    wb(1'b1, 8'h48, 16'h0000);
  endtask
  task automatic t_mirror();
    i_host.fire(8'h0, 8'h0, 6'h28, 3'h0, 3'h0, 11'h0);
    rc(8'h42, 16'h2100);
    chk("summary pins", {12'h000, summary_flags}, 16'h0009);
    wb(1'b1, 8'h42, 16'hdfff);
    rc(8'h40, 16'h0100);
    wb(1'b1, 8'h42, 16'h0000);
    rc(8'h40, 16'h0000);
  endtask
  task automatic t_frame();
    i_host.fire(8'h0, 8'h0, 6'h10, 3'h0, 3'h0, 11'h3a5);
    rc(8'h4c, 16'h03a5);
    rc(8'h40, 16'h2000);
    wb(1'b1, 8'h40, 16'hdfff);
    wb(1'b1, 8'h4c, 16'h0fff);
    rc(8'h4c, 16'h0ba5);
    i_host.fire(8'h0, 8'h0, 6'h18, 3'h0, 3'h0, 11'h123);
    rc(8'h40, 16'h0000);
    i_host.fire(8'h0, 8'h0, 6'h04, 3'h0, 3'h0, 11'h555);
    rc(8'h40, 16'h2000);
    rc(8'h4c, 16'h0923);
    wb(1'b1, 8'h40, 16'hdfff);
  endtask
  task automatic t_iso();
    i_host.fire(8'h0, 8'h0, 6'h02, 3'h4, 3'h3, 11'h0);
    i_host.fire(8'h0, 8'h0, 6'h02, 3'h2, 3'h5, 11'h0);
    i_host.fire(8'h0, 8'h0, 6'h01, 3'h1, 3'h6, 11'h0);
    i_host.fire(8'h0, 8'h0, 6'h02, 3'h0, 3'h1, 11'h0);
    rc(8'h4c, 16'hc923);
    rc(8'h48, 16'h0068);
    chk("discards", 16'(n_drop), 16'h0002);
    chk("zero-length", 16'(n_zlp), 16'h0001);
    wb(1'b1, 8'h4c, 16'h3fff);
    rc(8'h4c, 16'h0923);
  endtask
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_pipes();
    t_mirror();
    t_frame();
    t_iso();
    end_of_test();
  end
endmodule
